// ===== core/half_bridge_pkg.sv
// constants and carrier types for the half-bridge fault protection block
package half_bridge_pkg;

   localparam int CLK_FREQ_MHZ = 100;
   localparam int NUM_DRV = 6;
   localparam int NUM_CH = 3;
   localparam int FRAME_BITS = 16;
   localparam int TMR_W = 15;

   // command frame bit positions
   localparam int CMD_OVERVOLTAGE_LOCK_ENABLE_BIT = 15;
   localparam int CMD_UNDERLOAD_SHUTDOWN_ENABLE_BIT = 14;
   localparam int CMD_OCD_BIT = 13;
   localparam int CMD_DRV_LSB = 1;
   localparam int CMD_SRR_BIT = 0;

   // status frame bit positions
   localparam int ST_PSF_BIT = 15;
   localparam int ST_ULD_BIT = 14;
   localparam int ST_OC_BIT = 13;
   localparam int ST_STA_BIT = 12;
   localparam int ST_TW_BIT = 0;

   // delays in microseconds and in cycles
   localparam int OC_SHORT_US = 25;
   localparam int OC_LONG_US = 200;
   localparam int UL_DELAY_US = 100;
   localparam int OC_SHORT_CYC = OC_SHORT_US * CLK_FREQ_MHZ;
   localparam int OC_LONG_CYC = OC_LONG_US * CLK_FREQ_MHZ;
   localparam int UL_DELAY_CYC = UL_DELAY_US * CLK_FREQ_MHZ;
   localparam logic [TMR_W-1:0] OC_SHORT_T = TMR_W'(OC_SHORT_CYC);

   // wishbone register byte offsets
   localparam int WB_ADR_W = 4;
   localparam logic [WB_ADR_W-1:0] ADR_COMMAND = 4'h0;
   localparam logic [WB_ADR_W-1:0] ADR_STATUS = 4'h4;
   localparam logic [WB_ADR_W-1:0] ADR_DRIVE = 4'h8;

   // reset value and bit counter limit
   localparam logic [FRAME_BITS-1:0] CMD_RESET = 16'h0000;
   localparam logic [7:0] BIT_CNT_MAX = 8'hFF;

   // asynchronous inputs, sampled together
   typedef struct packed {
      logic ov;
      logic tsd;
      logic tw;
      logic [NUM_DRV-1:0] oc;
      logic [NUM_DRV-1:0] ul;
      logic sclk;
      logic csb_n;
      logic si;
   } sense_t;

   typedef struct packed {
      sense_t sync1;
      sense_t sync2;
      logic sclk_prev;
      logic csb_prev;
      logic [FRAME_BITS-1:0] shift;
      logic [7:0] bit_cnt;
      logic si_bit;
      logic so;
      logic so_oe;
      logic [FRAME_BITS-1:0] cmd;
      logic supply_fail_flag;
      logic underload_flag;
      logic overcurrent_flag;
      logic shoot_through_flag;
      logic tw;
      logic therm;
      logic [NUM_CH-1:0] st_block;
      logic [NUM_DRV-1:0] oc_latch;
      logic [NUM_DRV-1:0] ul_latch;
      logic [NUM_DRV-1:0][TMR_W-1:0] oc_cnt;
      logic [NUM_DRV-1:0] oc_long;
      logic [TMR_W-1:0] ul_cnt;
      logic [NUM_DRV-1:0] drive;
      logic ack;
      logic [31:0] rdata;
   } state_t;

endpackage

// ===== core/half_bridge_fault_protection.sv
// fault protection, serial frame port and wishbone registers of the triple half-bridge driver
`timescale 1ns/10ps
`default_nettype none

module half_bridge_fault_protection #(
   parameter int unsigned OC_LONG_CYC = half_bridge_pkg::OC_LONG_CYC,
   parameter int unsigned UL_DELAY_CYC = half_bridge_pkg::UL_DELAY_CYC
) (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET,
   // wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [half_bridge_pkg::WB_ADR_W-1:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   // serial frame port
   input wire logic SPI_CSB_N,
   input wire logic SPI_SCLK,
   input wire logic SPI_SI,
   output logic SPI_SO,
   output logic SPI_SO_OE,
   // analog sensing
   input wire logic SUPPLY_OV,
   input wire logic THERMAL_WARN,
   input wire logic THERMAL_SHUTDOWN,
   input wire logic [half_bridge_pkg::NUM_DRV-1:0] OVERCURRENT,
   input wire logic [half_bridge_pkg::NUM_DRV-1:0] UNDERLOAD,
   // driver gates: index 2c is low side, 2c+1 high side of channel c
   output logic [half_bridge_pkg::NUM_DRV-1:0] DRIVE_ON
);

   localparam logic [half_bridge_pkg::TMR_W-1:0] OC_LONG_T = half_bridge_pkg::TMR_W'(OC_LONG_CYC);
   localparam logic [half_bridge_pkg::TMR_W-1:0] UL_T = half_bridge_pkg::TMR_W'(UL_DELAY_CYC);

   half_bridge_pkg::state_t s_q;
   half_bridge_pkg::state_t s_d;
   half_bridge_pkg::sense_t sense_in;

   logic sclk_rise;
   logic sclk_fall;
   logic csb_fall;
   logic csb_rise;
   logic spi_done;
   logic wb_go;
   logic wb_cmd_wr;
   logic apply;
   logic status_reset_request;
   logic [15:0] wb_frame;
   logic [15:0] frame;
   logic [15:0] status;
   logic [half_bridge_pkg::NUM_CH-1:0] both_on;
   logic [half_bridge_pkg::NUM_DRV-1:0] oc_cond;
   logic [half_bridge_pkg::NUM_DRV-1:0] ul_cond;
   logic [half_bridge_pkg::NUM_DRV-1:0] blk_mask;
   logic ul_any;
   logic ul_expire;
   logic ov;
   logic tsd;

   assign sense_in = '{ov: SUPPLY_OV, tsd: THERMAL_SHUTDOWN, tw: THERMAL_WARN, oc: OVERCURRENT,
                       ul: UNDERLOAD, sclk: SPI_SCLK, csb_n: SPI_CSB_N, si: SPI_SI};

   assign ov = s_q.sync2.ov;
   assign tsd = s_q.sync2.tsd;
   assign sclk_rise = s_q.sync2.sclk & ~s_q.sclk_prev;
   assign sclk_fall = ~s_q.sync2.sclk & s_q.sclk_prev;
   assign csb_fall = ~s_q.sync2.csb_n & s_q.csb_prev;
   assign csb_rise = s_q.sync2.csb_n & ~s_q.csb_prev;
   // a frame is valid when a whole number of 16-bit words, at most 240 bits, was clocked
   assign spi_done = csb_rise && (s_q.bit_cnt != 8'h00) && (s_q.bit_cnt[3:0] == 4'h0);

   // a register write never collides with a serial frame: the bus waits one cycle
   assign wb_go = WB_CYC_I & WB_STB_I & ~s_q.ack & ~(WB_WE_I & spi_done);
   assign wb_cmd_wr = wb_go & WB_WE_I & (WB_ADR_I == half_bridge_pkg::ADR_COMMAND);
   assign wb_frame = {(WB_SEL_I[1] ? WB_DAT_I[15:8] : s_q.cmd[15:8]),
                      (WB_SEL_I[0] ? WB_DAT_I[7:0] : s_q.cmd[7:0])};
   assign apply = spi_done | wb_cmd_wr;
   assign frame = spi_done ? s_q.shift : wb_frame;
   assign status_reset_request = apply & frame[half_bridge_pkg::CMD_SRR_BIT];

   assign status = {s_q.supply_fail_flag, s_q.underload_flag, s_q.overcurrent_flag, s_q.shoot_through_flag, 5'h00, s_q.drive, s_q.tw};

   assign oc_cond = s_q.drive & s_q.sync2.oc;
   assign ul_cond = s_q.drive & s_q.sync2.ul;
   assign ul_any = |ul_cond;
   assign ul_expire = ul_any && (s_q.ul_cnt >= UL_T);

   genvar gc;
   generate
      for (gc = 0; gc < half_bridge_pkg::NUM_CH; gc++) begin : g_ch
         assign both_on[gc] = frame[2 * gc + 1] & frame[2 * gc + 2];
         assign blk_mask[2 * gc] = s_q.st_block[gc];
         assign blk_mask[2 * gc + 1] = s_q.st_block[gc];
      end
   endgenerate

   always_comb begin
      logic [half_bridge_pkg::TMR_W-1:0] oc_term;
      logic ch_both;
      oc_term = half_bridge_pkg::OC_SHORT_T;
      ch_both = 1'b0;
      s_d = s_q;

      // two-stage synchronisers and edge history
      s_d.sync1 = sense_in;
      s_d.sync2 = s_q.sync1;
      s_d.sclk_prev = s_q.sync2.sclk;
      s_d.csb_prev = s_q.sync2.csb_n;

      // serial shift: status goes out while the command comes in
      if (csb_fall) begin
         s_d.shift = status;
         s_d.bit_cnt = 8'h00;
         s_d.so_oe = 1'b1;
      end else if (!s_q.sync2.csb_n) begin
         if (sclk_rise) begin
            s_d.si_bit = s_q.sync2.si;
            if (s_q.bit_cnt != half_bridge_pkg::BIT_CNT_MAX) begin
               s_d.bit_cnt = s_q.bit_cnt + 8'h01;
            end
         end
         if (sclk_fall) begin
            s_d.shift = {s_q.shift[14:0], s_q.si_bit};
         end
      end
      if (csb_rise) begin
         s_d.so_oe = 1'b0;
      end
      s_d.so = s_d.shift[15];

      // status reset first, so that any event of this cycle sets again
      if (status_reset_request) begin
         s_d.supply_fail_flag = 1'b0;
         s_d.underload_flag = 1'b0;
         s_d.overcurrent_flag = 1'b0;
         s_d.shoot_through_flag = 1'b0;
         s_d.tw = 1'b0;
         s_d.therm = 1'b0;
         s_d.st_block = '0;
         s_d.oc_latch = '0;
         s_d.ul_latch = '0;
      end
      if (ov) begin
         s_d.supply_fail_flag = 1'b1;
      end
      if (s_q.sync2.tw) begin
         s_d.tw = 1'b1;
      end
      if (tsd) begin
         s_d.therm = 1'b1;
      end

      // command update; programmed states survive every fault
      if (apply) begin
         s_d.cmd = frame;
         for (int c = 0; c < half_bridge_pkg::NUM_CH; c++) begin
            if (both_on[c]) begin
               s_d.st_block[c] = 1'b1;
               s_d.shoot_through_flag = 1'b1;
            end
         end
      end

      // per-driver overcurrent delay, setting frozen at its start
      for (int i = 0; i < half_bridge_pkg::NUM_DRV; i++) begin
         if (oc_cond[i]) begin
            if (s_q.oc_cnt[i] == '0) begin
               s_d.oc_long[i] = ~s_q.cmd[half_bridge_pkg::CMD_OCD_BIT];
            end
            if ((s_q.oc_cnt[i] == '0) ? ~s_q.cmd[half_bridge_pkg::CMD_OCD_BIT] : s_q.oc_long[i]) begin
               oc_term = OC_LONG_T;
            end else begin
               oc_term = half_bridge_pkg::OC_SHORT_T;
            end
            if (s_q.oc_cnt[i] >= oc_term) begin
               s_d.oc_latch[i] = 1'b1;
               s_d.overcurrent_flag = 1'b1;
               s_d.oc_cnt[i] = '0;
            end else begin
               s_d.oc_cnt[i] = s_q.oc_cnt[i] + 15'h0001;
            end
         end else begin
            s_d.oc_cnt[i] = '0;
         end
      end

      // one shared underload timer, started by the first underload
      if (ul_any) begin
         if (ul_expire) begin
            for (int i = 0; i < half_bridge_pkg::NUM_DRV; i++) begin
               if (ul_cond[i]) begin
                  s_d.underload_flag = 1'b1;
                  if (s_q.cmd[half_bridge_pkg::CMD_UNDERLOAD_SHUTDOWN_ENABLE_BIT]) begin
                     s_d.ul_latch[i] = 1'b1;
                  end
               end
            end
         end else begin
            s_d.ul_cnt = s_q.ul_cnt + 15'h0001;
         end
      end else begin
         s_d.ul_cnt = '0;
      end

      // gate the programmed commands with every shutdown
      for (int i = 0; i < half_bridge_pkg::NUM_DRV; i++) begin
         ch_both = s_d.cmd[2 * (i / 2) + 1] & s_d.cmd[2 * (i / 2) + 2];
         s_d.drive[i] = s_d.cmd[half_bridge_pkg::CMD_DRV_LSB + i]
                        & ~(ov & s_d.cmd[half_bridge_pkg::CMD_OVERVOLTAGE_LOCK_ENABLE_BIT])
                        & ~s_d.st_block[i / 2] & ~ch_both
                        & ~s_d.oc_latch[i]
                        & ~s_d.ul_latch[i]
                        & ~s_d.therm & ~tsd;
      end

      // wishbone answer one cycle after the request
      s_d.ack = wb_go;
      s_d.rdata = 32'h0000_0000;
      if (wb_go && !WB_WE_I) begin
         unique case (WB_ADR_I)
            half_bridge_pkg::ADR_COMMAND: s_d.rdata = {16'h0000, s_q.cmd};
            half_bridge_pkg::ADR_STATUS: s_d.rdata = {16'h0000, status};
            half_bridge_pkg::ADR_DRIVE: s_d.rdata = {26'h0000000, s_q.drive};
            default: s_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         s_q <= '0;
         // select idles high, so no false select edge follows reset
         s_q.sync1.csb_n <= 1'b1;
         s_q.sync2.csb_n <= 1'b1;
         s_q.csb_prev <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign DRIVE_ON = s_q.drive;
   assign SPI_SO = s_q.so;
   assign SPI_SO_OE = s_q.so_oe;
   assign WB_DAT_O = s_q.rdata;
   assign WB_ACK_O = s_q.ack;

   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RESET);

   property p_psf_set;
      ov |=> s_q.supply_fail_flag;
   endproperty
   a_psf_set: assert property (p_psf_set) else $error("supply fail flag not set");

   property p_ov_keep;
      (ov && !s_q.cmd[half_bridge_pkg::CMD_OVERVOLTAGE_LOCK_ENABLE_BIT] && !apply && !tsd && !s_q.therm
       && s_q.drive == s_q.cmd[6:1]) |=> (DRIVE_ON == $past(s_q.cmd[6:1])) || (s_q.oc_latch != '0)
       || (s_q.ul_latch != '0) || s_q.therm;
   endproperty
   a_ov_keep: assert property (p_ov_keep) else $error("outputs changed on unlocked overvoltage");

   property p_ov_lock;
      (ov && s_q.cmd[half_bridge_pkg::CMD_OVERVOLTAGE_LOCK_ENABLE_BIT] && !apply) |=> (DRIVE_ON == '0);
   endproperty
   a_ov_lock: assert property (p_ov_lock) else $error("driver on during overvoltage lock");

   property p_psf_hold;
      (s_q.supply_fail_flag && !status_reset_request) |=> s_q.supply_fail_flag;
   endproperty
   a_psf_hold: assert property (p_psf_hold) else $error("supply fail flag lost");

   property p_sta_set;
      (apply && (both_on != '0)) |=> (s_q.shoot_through_flag && (s_q.st_block != '0) && (DRIVE_ON & blk_mask) == '0);
   endproperty
   a_sta_set: assert property (p_sta_set) else $error("shoot-through not caught");

   property p_sta_off;
      (s_q.st_block != '0) |-> ((DRIVE_ON & blk_mask) == '0) && s_q.shoot_through_flag;
   endproperty
   a_sta_off: assert property (p_sta_off) else $error("blocked channel driven");

   property p_oc_trip;
      (oc_cond[0] && !s_q.oc_long[0] && s_q.oc_cnt[0] == half_bridge_pkg::OC_SHORT_T)
      |=> (s_q.oc_latch[0] && s_q.overcurrent_flag && !DRIVE_ON[0]);
   endproperty
   a_oc_trip: assert property (p_oc_trip) else $error("overcurrent trip missed");

   property p_oc_latch_hold;
      (s_q.oc_latch[0] && !status_reset_request) |=> (s_q.oc_latch[0] && !DRIVE_ON[0]);
   endproperty
   a_oc_latch_hold: assert property (p_oc_latch_hold) else $error("overcurrent latch released");

   property p_oc_freeze;
      (oc_cond[0] && s_q.oc_cnt[0] != '0) |=> (s_q.oc_long[0] == $past(s_q.oc_long[0]));
   endproperty
   a_oc_freeze: assert property (p_oc_freeze) else $error("delay setting changed mid-count");

   property p_ul_shut;
      (ul_expire && ul_cond[0] && s_q.cmd[half_bridge_pkg::CMD_UNDERLOAD_SHUTDOWN_ENABLE_BIT]) |=> (s_q.underload_flag && s_q.ul_latch[0]);
   endproperty
   a_ul_shut: assert property (p_ul_shut) else $error("underload shutdown missed");

   property p_ul_restart;
      !ul_any |=> (s_q.ul_cnt == '0);
   endproperty
   a_ul_restart: assert property (p_ul_restart) else $error("underload timer not restarted");

   property p_underload_flag_hold;
      (s_q.underload_flag && !status_reset_request) |=> s_q.underload_flag;
   endproperty
   a_underload_flag_hold: assert property (p_underload_flag_hold) else $error("underload flag lost");

   property p_sta_hold;
      (s_q.shoot_through_flag && !status_reset_request) |=> s_q.shoot_through_flag;
   endproperty
   a_sta_hold: assert property (p_sta_hold) else $error("shoot-through flag lost");

   property p_overcurrent_flag_hold;
      (s_q.overcurrent_flag && !status_reset_request) |=> s_q.overcurrent_flag;
   endproperty
   a_overcurrent_flag_hold: assert property (p_overcurrent_flag_hold) else $error("overcurrent flag lost");

   property p_oc_long_trip;
      (oc_cond[0] && s_q.oc_long[0] && s_q.oc_cnt[0] == OC_LONG_T) |=> (s_q.oc_latch[0] && !DRIVE_ON[0]);
   endproperty
   a_oc_long_trip: assert property (p_oc_long_trip) else $error("long overcurrent trip missed");

   property p_ul_flag;
      ul_expire |=> s_q.underload_flag;
   endproperty
   a_ul_flag: assert property (p_ul_flag) else $error("underload flag not set");

   property p_ul_keep;
      (ul_expire && !s_q.cmd[half_bridge_pkg::CMD_UNDERLOAD_SHUTDOWN_ENABLE_BIT] && !status_reset_request) |=> (s_q.ul_latch == $past(s_q.ul_latch));
   endproperty
   a_ul_keep: assert property (p_ul_keep) else $error("underload latched with shutdown off");

   property p_srr_clear;
      (status_reset_request && !ov && !s_q.sync2.tw) |=> (!s_q.supply_fail_flag && !s_q.tw);
   endproperty
   a_srr_clear: assert property (p_srr_clear) else $error("status reset did not clear flags");

   property p_tsd_off;
      tsd |=> (DRIVE_ON == '0) && s_q.therm;
   endproperty
   a_tsd_off: assert property (p_tsd_off) else $error("driver on in thermal shutdown");

endmodule

`default_nettype wire

// ===== testbench/spi_host.sv
// serial host model: sends one command frame and captures the status word
`timescale 1ns/10ps
`default_nettype none
module spi_host (
   // system clock used to time the link
   input wire logic clk,
   // serial lines
   input wire logic so,
   output logic csb_n,
   output logic sclk,
   output logic si
);
   // link idles with select high and clock parked low
   initial begin
      csb_n = 1'b1;
      sclk = 1'b0;
      si = 1'b0;
   end
   // four system cycles per half, and three halves per bit give a 120 ns link clock
   task automatic half();
      repeat (4) @(posedge clk);
   endtask
   task automatic send(input logic [15:0] cmd, output logic [15:0] st);
      integer i;
      csb_n <= 1'b0;
      for (i = 15; i >= 0; i--) begin
         half();
         si <= cmd[i];
         half();
         sclk <= 1'b1;
         st[i] = so;
         half();
         sclk <= 1'b0;
      end
      half();
      // data line falls back to its pull-down level once released
      si <= 1'b0;
      csb_n <= 1'b1;
      half();
   endtask
endmodule
`default_nettype wire

// ===== testbench/half_bridge_fault_protection_tb.sv
// self-checking bench of the half-bridge fault protection block
`timescale 1ns/10ps
`default_nettype none
module half_bridge_fault_protection_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] rdat;
   logic ack;
   wire logic csb_n;
   wire logic sclk;
   wire logic si;
   logic so;
   logic so_oe;
   wire logic so_pin;
   logic ov = 1'b0;
   logic tw = 1'b0;
   logic tsd = 1'b0;
   logic [5:0] oc = 6'h00;
   logic [5:0] ul = 6'h00;
   logic [5:0] drv;
   logic [31:0] r;
   logic [15:0] s;
   int err_total = 0;
   int samples_checked = 0;

   always #5 clk = ~clk;

   half_bridge_fault_protection #(.OC_LONG_CYC(400), .UL_DELAY_CYC(200)) dut (
      .SYS_CLK(clk), .RESET(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .SPI_CSB_N(csb_n), .SPI_SCLK(sclk), .SPI_SI(si), .SPI_SO(so), .SPI_SO_OE(so_oe),
      .SUPPLY_OV(ov), .THERMAL_WARN(tw), .THERMAL_SHUTDOWN(tsd), .OVERCURRENT(oc),
      .UNDERLOAD(ul), .DRIVE_ON(drv));

   // a released serial output shows the inverse, so a missing enable corrupts the status
   assign so_pin = so_oe ? so : ~so;
   spi_host host (.clk(clk), .so(so_pin), .csb_n(csb_n), .sclk(sclk), .si(si));

   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic cy(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'h3;
      wdat <= {16'h0000, d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      r = rdat;
      if (n >= 50) begin
         err_total++;
         $display("MISMATCH t=%0t bus timeout", $time);
         results();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic cmd(input logic [15:0] d);
      wb(1'b1, 4'h0, d);
      cy(3);
   endtask
   task automatic stat(input logic [15:0] mask, input logic [15:0] exp);
      wb(1'b0, 4'h4, 16'h0000);
      chk(r[15:0] & mask, exp, "status");
   endtask
   task automatic dchk(input logic [5:0] exp);
      chk({10'h000, drv}, {10'h000, exp}, "drive");
   endtask

   task automatic t_ov();
      cmd(16'h0002);
      ov <= 1'b1;
      cy(5);
      dchk(6'h01);
      stat(16'h8000, 16'h8000);
      cmd(16'h8002);
      dchk(6'h00);
      ov <= 1'b0;
      cy(5);
      dchk(6'h01);
      stat(16'h8000, 16'h8000);
      cmd(16'h8003);
      stat(16'h8000, 16'h0000);
      $display("test overvoltage done");
   endtask
   task automatic t_sta();
      host.send(16'h0006, s);
      cy(10);
      dchk(6'h00);
      stat(16'h1000, 16'h1000);
      chk({15'h0000, so_oe}, 16'h0000, "output enable after frame");
      host.send(16'h0004, s);
      cy(10);
      dchk(6'h00);
      chk(s & 16'hF000, 16'h1000, "serial status");
      host.send(16'h0005, s);
      cy(10);
      dchk(6'h02);
      stat(16'h1000, 16'h0000);
      $display("test shoot-through done");
   endtask
   task automatic t_oc();
      cmd(16'h2002);
      oc <= 6'h01;
      cy(2400);
      dchk(6'h01);
      cy(200);
      dchk(6'h00);
      stat(16'h2000, 16'h2000);
      oc <= 6'h00;
      cmd(16'h0002);
      dchk(6'h00);
      cmd(16'h0003);
      dchk(6'h01);
      oc <= 6'h01;
      cy(100);
      cmd(16'h2002);
      cy(240);
      dchk(6'h01);
      cy(100);
      dchk(6'h00);
      oc <= 6'h00;
      cmd(16'h0001);
      $display("test overcurrent done");
   endtask
   task automatic t_ul();
      cmd(16'h400A);
      ul <= 6'h01;
      cy(100);
      ul <= 6'h05;
      cy(80);
      dchk(6'h05);
      cy(40);
      dchk(6'h00);
      stat(16'h4000, 16'h4000);
      ul <= 6'h00;
      cmd(16'h000B);
      stat(16'h4000, 16'h0000);
      ul <= 6'h01;
      cy(150);
      ul <= 6'h00;
      cy(10);
      ul <= 6'h01;
      cy(150);
      stat(16'h4000, 16'h0000);
      cy(100);
      dchk(6'h05);
      cmd(16'h000A);
      stat(16'h4000, 16'h4000);
      ul <= 6'h00;
      cy(3);
      cmd(16'h0001);
      stat(16'h4000, 16'h0000);
      $display("test underload done");
   endtask
   task automatic t_tsd();
      tw <= 1'b1;
      tsd <= 1'b1;
      cmd(16'h0002);
      dchk(6'h00);
      stat(16'h0001, 16'h0001);
      tsd <= 1'b0;
      tw <= 1'b0;
      cy(5);
      cmd(16'h0003);
      dchk(6'h01);
      wb(1'b0, 4'hC, 16'h0000);
      chk(r[15:0], 16'h0000, "unmapped");
      cmd(16'h0000);
      $display("test thermal done");
   endtask

   initial begin
      cy(5);
      rst <= 1'b0;
      cy(5);
      t_ov();
      t_sta();
      t_oc();
      t_ul();
      t_tsd();
      results();
   end
endmodule
`default_nettype wire
